/* cps_ctl_status.sv */
/*
 * control and status registers of the content-protection transmitter:
 * control writes start, restart and approve authentication steps and
 * steer encryption; status reads report the downstream receiver.
 * assumes the authentication engine and link logic share clk and
 * deliver one-cycle event pulses; sink pins come from outside.
 */
// Summary of operation
// R1: list approval after revocation check; self-clearing
// R2: key approval after check continues authentication
// R3: key approval cleared by key ready; zero ignored
// R4: suppress write sends plain video, keeps authentication
// R5: enable set: encrypt if auth_done_flag, else blue
// R6: enable clear: video sent unencrypted
// R7: always-encrypt policy makes enable read one
// R8: controller should keep encryption enabled for content
// R9: enable write one starts or restarts authentication
// R10: enable zero write ignored; read returns state
// R11: side channel error flag, clear on read
// R12: sink irq bit mirrors active low pin
// R13: sink lock bit mirrors receiver lock
// R14: hotplug flag set by repeater, clear on read
// R15: present bit shows detected downstream receiver
// R16: list ready flag pauses until list approval
// R17: list approval clears list ready flag
// R18: key ready flag set, wait for approval
// R19: done flag set on pass, cleared on loss/restart
// R20: policy codes: auth_done_flag, register, always, in-band
// R21: self-clearing control bits read back zero; list and key approval read one in the cycle after their write
// R22: read clears only returned flags; new events stay
module cps_ctl_status
    import cps_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access port
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // configuration and frame control
    input wire logic [1:0] enc_policy,
    input wire logic frame_enc_req,
    // sink pins
    input wire cps_pin_s sink_pins,
    // engine and link events
    input wire cps_evt_s evt,
    // engine controls
    output logic auth_enable,
    output logic auth_restart,
    output logic key_approved,
    output logic list_approved,
    output logic protect_reset,
    // video path controls
    output logic encrypt_on,
    output logic blue_screen
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cps_state_s s;
    cps_state_s next_s;
    logic srst_n;
    logic wr_ctl;
    logic rd_sts;
    logic want_enc;
    logic enc_read;
    logic [7:0] sts_vec;
    logic [7:0] ctl_vec;

    assign srst_n = s.rst_sync[1];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.rst_sync = {s.rst_sync[0], 1'b1};
        next_s.pin_m = sink_pins;
        next_s.pin_s = s.pin_m;
        wr_ctl = wr_en && (addr == CPS_ADDR_CTL);
        rd_sts = rd_en && (addr == CPS_ADDR_STS);
        enc_read = (enc_policy == CPS_POL_ALWAYS) ? 1'b1 : s.enc_en; // R7
        sts_vec = 8'h00;
        sts_vec[CPS_S_SIDE_ERR] = s.err_f;
        sts_vec[CPS_S_SINK_IRQ] = s.pin_s.irq_n; // R12
        sts_vec[CPS_S_SINK_LOCK] = s.pin_s.lock; // R13
        sts_vec[CPS_S_HOTPLUG] = s.hpd_f;
        sts_vec[CPS_S_PRESENT] = s.pin_s.present; // R15
        sts_vec[CPS_S_LIST_RDY] = s.list_rdy;
        sts_vec[CPS_S_KEY_RDY] = s.key_rdy;
        sts_vec[CPS_S_AUTH_DONE_FLAG] = s.auth_done_flag;
        ctl_vec = 8'h00;
        ctl_vec[CPS_C_LIST_APPR] = s.list_appr; // R21
        ctl_vec[CPS_C_KEY_APPR] = s.key_appr;
        ctl_vec[CPS_C_SUPPRESS] = 1'b0; // R4
        ctl_vec[CPS_C_ENC_EN] = enc_read;
        ctl_vec[CPS_C_AUTH_EN] = s.auth_en; // R10
        // one-cycle strobes toward the engine
        next_s.auth_restart = 1'b0;
        next_s.key_appr = 1'b0;
        next_s.list_appr = 1'b0;
        next_s.prot_reset = 1'b0;
        if (wr_ctl)
        begin
            if (wr_data[CPS_C_RESET])
            begin
                next_s.auth_en = 1'b0;
                next_s.prot_reset = 1'b1;
            end
            else if (wr_data[CPS_C_DISABLE])
            begin
                next_s.auth_en = 1'b0;
            end
            else if (wr_data[CPS_C_AUTH_EN])
            begin
                next_s.auth_en = 1'b1; // R9
                next_s.auth_restart = 1'b1; // R9
            end
            next_s.list_appr = wr_data[CPS_C_LIST_APPR]; // R1
            next_s.key_appr = wr_data[CPS_C_KEY_APPR] && !evt.key_rdy; // R2 R3
            if (enc_policy != CPS_POL_ALWAYS)
            begin
                next_s.enc_en = wr_data[CPS_C_ENC_EN]; // R7
            end
            if (wr_data[CPS_C_SUPPRESS])
            begin
                next_s.suppress = 1'b1; // R4
            end
            else if (wr_data[CPS_C_ENC_EN] || wr_data[CPS_C_AUTH_EN])
            begin
                next_s.suppress = 1'b0;
            end
        end
        // sticky flags: set wins over clear, but a restart or protect reset blocks a pass
        if (wr_ctl && wr_data[CPS_C_LIST_APPR])
        begin
            next_s.list_rdy = 1'b0; // R17
        end
        if (evt.list_rdy)
        begin
            next_s.list_rdy = 1'b1; // R16
        end
        if (wr_ctl && wr_data[CPS_C_KEY_APPR])
        begin
            next_s.key_rdy = 1'b0;
        end
        if (evt.key_rdy)
        begin
            next_s.key_rdy = 1'b1; // R18
        end
        if (evt.auth_lost || next_s.auth_restart || next_s.prot_reset
            || (wr_ctl && wr_data[CPS_C_DISABLE]))
        begin
            next_s.auth_done_flag = 1'b0; // R19
        end
        if (evt.auth_pass && !next_s.auth_restart && !next_s.prot_reset)
        begin
            next_s.auth_done_flag = 1'b1; // R19
        end
        if (rd_sts && s.err_f)
        begin
            next_s.err_f = 1'b0; // R22
        end
        if (evt.side_err)
        begin
            next_s.err_f = 1'b1; // R11
        end
        if (rd_sts && s.hpd_f)
        begin
            next_s.hpd_f = 1'b0; // R22
        end
        if (evt.hotplug)
        begin
            next_s.hpd_f = 1'b1; // R14
        end
        // read data
        if (rd_en)
        begin
            if (addr == CPS_ADDR_STS)
            begin
                next_s.rd_data = sts_vec;
            end
            else if (addr == CPS_ADDR_CTL)
            begin
                next_s.rd_data = ctl_vec;
            end
            else
            begin
                next_s.rd_data = 8'h00;
            end
        end
        // video path selection
        case (enc_policy) // R20
            CPS_POL_AUTH_DONE_FLAG: want_enc = s.auth_done_flag;
            CPS_POL_REG: want_enc = s.enc_en; // R5 R6
            CPS_POL_ALWAYS: want_enc = 1'b1;
            default: want_enc = s.enc_en && frame_enc_req;
        endcase
        next_s.enc_on = want_enc && s.auth_done_flag && !s.suppress; // R5
        next_s.blue = want_enc && !s.auth_done_flag && !s.suppress; // R5
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else if (!srst_n)
        begin
            s <= '0;
            s.rst_sync <= next_s.rst_sync;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign rd_data = s.rd_data;
    assign auth_enable = s.auth_en;
    assign auth_restart = s.auth_restart;
    assign key_approved = s.key_appr;
    assign list_approved = s.list_appr;
    assign protect_reset = s.prot_reset;
    assign encrypt_on = s.enc_on;
    assign blue_screen = s.blue;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_list_pulse: assert property (@(posedge clk) disable iff (!srst_n) // R1
        list_approved && !(wr_ctl && wr_data[CPS_C_LIST_APPR])
        |=> !list_approved)
        else $error("list approval not self-clearing");
    chk_key_appr: assert property (@(posedge clk) disable iff (!srst_n) // R2
        wr_ctl && wr_data[CPS_C_KEY_APPR] && !evt.key_rdy |=> key_approved)
        else $error("key approval not forwarded");
    chk_key_zero: assert property (@(posedge clk) disable iff (!srst_n) // R3
        wr_ctl && !wr_data[CPS_C_KEY_APPR] |=> !key_approved)
        else $error("zero write approved key");
    chk_suppress_plain: assert property ( // R4
        @(posedge clk) disable iff (!srst_n)
        s.suppress |=> !encrypt_on && !blue_screen)
        else $error("video not plain while suppressed");
    chk_blue_unauth: assert property ( // R5
        @(posedge clk) disable iff (!srst_n)
        enc_policy == CPS_POL_ALWAYS && !s.auth_done_flag && !s.suppress
        |=> blue_screen)
        else $error("blue screen missing");
    chk_plain_off: assert property (@(posedge clk) disable iff (!srst_n) // R6
        enc_policy == CPS_POL_REG && !s.enc_en |=> !encrypt_on && !blue_screen)
        else $error("encrypting with enable clear");
    chk_always_one: assert property (@(posedge clk) disable iff (!srst_n) // R7
        rd_en && addr == CPS_ADDR_CTL && enc_policy == CPS_POL_ALWAYS
        |=> rd_data[CPS_C_ENC_EN])
        else $error("enable not read as one");
    chk_restart: assert property (@(posedge clk) disable iff (!srst_n) // R9
        wr_ctl && wr_data == 8'h01 |=> auth_restart && auth_enable ##1
        (!auth_restart || $past(wr_ctl && wr_data[CPS_C_AUTH_EN])))
        else $error("restart not issued");
    chk_en_hold: assert property (@(posedge clk) disable iff (!srst_n) // R10
        wr_ctl && wr_data == 8'h00 |=> auth_enable == $past(auth_enable))
        else $error("zero write changed enable");
    chk_err_cor: assert property (@(posedge clk) disable iff (!srst_n) // R11
        rd_sts && s.err_f && !evt.side_err |=> rd_data[CPS_S_SIDE_ERR]
        && !s.err_f)
        else $error("error flag not cleared on read");
    chk_irq_mirror: assert property ( // R12
        @(posedge clk) disable iff (!srst_n)
        rd_sts |=> rd_data[CPS_S_SINK_IRQ] == $past(s.pin_s.irq_n))
        else $error("irq bit mismatch");
    chk_list_clear: assert property ( // R17
        @(posedge clk) disable iff (!srst_n)
        wr_ctl && wr_data[CPS_C_LIST_APPR] && !evt.list_rdy |=> !s.list_rdy)
        else $error("list ready not cleared");
    chk_auth_drop: assert property (@(posedge clk) disable iff (!srst_n) // R19
        evt.auth_lost && !evt.auth_pass |=> !s.auth_done_flag)
        else $error("done flag kept after loss");
    chk_evt_kept: assert property (@(posedge clk) disable iff (!srst_n) // R22
        rd_sts && evt.hotplug |=> s.hpd_f)
        else $error("hotplug event lost during read");

    // ------------------------------------------------------------
    // flag, readback, strobe and video path checks
    // ------------------------------------------------------------
    chk_lock_bit: assert property (@(posedge clk) disable iff (!srst_n) // R13
        rd_sts |=> rd_data[CPS_S_SINK_LOCK] == $past(s.pin_s.lock))
        else $error("lock bit mismatch");
    chk_pres_bit: assert property (@(posedge clk) disable iff (!srst_n) // R15
        rd_sts |=> rd_data[CPS_S_PRESENT] == $past(s.pin_s.present))
        else $error("present bit mismatch");
    chk_hpd_set: assert property (@(posedge clk) disable iff (!srst_n) // R14
        evt.hotplug |=> s.hpd_f)
        else $error("hotplug flag not set");
    chk_err_set: assert property (@(posedge clk) disable iff (!srst_n) // R11
        evt.side_err |=> s.err_f)
        else $error("error flag not set");
    chk_list_set: assert property (@(posedge clk) disable iff (!srst_n) // R16
        evt.list_rdy |=> s.list_rdy)
        else $error("list ready flag not set");
    chk_key_set: assert property (@(posedge clk) disable iff (!srst_n) // R18
        evt.key_rdy |=> s.key_rdy)
        else $error("key ready flag not set");
    chk_key_drop: assert property (@(posedge clk) disable iff (!srst_n) // R3
        evt.key_rdy
        |=> !key_approved)
        else $error("key approval kept with key ready");
    chk_auth_set: assert property (@(posedge clk) disable iff (!srst_n) // R19
        evt.auth_pass && !wr_ctl
        |=> s.auth_done_flag)
        else $error("done flag not set on pass");
    chk_frame_off: assert property (@(posedge clk) disable iff (!srst_n) // R20
        enc_policy == CPS_POL_INBAND && !frame_enc_req
        |=> !encrypt_on && !blue_screen)
        else $error("in-band frame not plain");
    chk_enc_fixed: assert property (@(posedge clk) disable iff (!srst_n) // R7
        wr_ctl && enc_policy == CPS_POL_ALWAYS
        |=> s.enc_en == $past(s.enc_en))
        else $error("read-only enable changed");
    chk_ctl_zero: assert property (@(posedge clk) disable iff (!srst_n) // R21
        rd_en && addr == CPS_ADDR_CTL
        |=> !rd_data[CPS_C_SUPPRESS] && !rd_data[CPS_C_RESET])
        else $error("self-clearing bit read as one");
    chk_enc_auth: assert property (@(posedge clk) disable iff (!srst_n) // R5
        !s.auth_done_flag |=> !encrypt_on)
        else $error("encrypting while not authenticated");
    chk_rst_pulse: assert property (@(posedge clk) disable iff (!srst_n) // R21
        protect_reset && !(wr_ctl && wr_data[CPS_C_RESET])
        |=> !protect_reset)
        else $error("protect reset not self-clearing");
    chk_dis_drop: assert property (@(posedge clk) disable iff (!srst_n) // R10
        wr_ctl && wr_data[CPS_C_DISABLE]
        |=> !auth_enable)
        else $error("disable write kept enable");

endmodule : cps_ctl_status

/* cps_pkg.sv */
/*
 * shared constants and carrier types of the content-protection
 * control and status register logic.
 * assumes a single clock domain and the documented register offsets.
 */
package cps_pkg;

    // ------------------------------------------------------------
    // register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CPS_ADDR_CTL = 8'hc3;
    localparam logic [7:0] CPS_ADDR_STS = 8'hc4;
    localparam logic [7:0] CPS_RST_CTL = 8'h00;
    localparam logic [7:0] CPS_RST_STS = 8'h00;

    // ------------------------------------------------------------
    // protect_control bit positions
    // ------------------------------------------------------------
    localparam int CPS_C_RESET = 7;
    localparam int CPS_C_LIST_APPR = 5;
    localparam int CPS_C_KEY_APPR = 4;
    localparam int CPS_C_SUPPRESS = 3;
    localparam int CPS_C_ENC_EN = 2;
    localparam int CPS_C_DISABLE = 1;
    localparam int CPS_C_AUTH_EN = 0;

    // ------------------------------------------------------------
    // protect_status bit positions
    // ------------------------------------------------------------
    localparam int CPS_S_SIDE_ERR = 7;
    localparam int CPS_S_SINK_IRQ = 6;
    localparam int CPS_S_SINK_LOCK = 5;
    localparam int CPS_S_HOTPLUG = 4;
    localparam int CPS_S_PRESENT = 3;
    localparam int CPS_S_LIST_RDY = 2;
    localparam int CPS_S_KEY_RDY = 1;
    localparam int CPS_S_AUTH_DONE_FLAG = 0;

    // ------------------------------------------------------------
    // encryption policy encodings
    // ------------------------------------------------------------
    localparam logic [1:0] CPS_POL_AUTH_DONE_FLAG = 2'h0;
    localparam logic [1:0] CPS_POL_REG = 2'h1;
    localparam logic [1:0] CPS_POL_ALWAYS = 2'h2;
    localparam logic [1:0] CPS_POL_INBAND = 2'h3;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic irq_n;
        logic lock;
        logic present;
    } cps_pin_s;

    typedef struct packed {
        logic key_rdy;
        logic list_rdy;
        logic auth_pass;
        logic auth_lost;
        logic side_err;
        logic hotplug;
    } cps_evt_s;

    typedef struct packed {
        logic [1:0] rst_sync;
        cps_pin_s pin_m;
        cps_pin_s pin_s;
        logic auth_en;
        logic auth_restart;
        logic key_appr;
        logic list_appr;
        logic prot_reset;
        logic suppress;
        logic enc_en;
        logic err_f;
        logic hpd_f;
        logic list_rdy;
        logic key_rdy;
        logic auth_done_flag;
        logic [7:0] rd_data;
        logic enc_on;
        logic blue;
    } cps_state_s;

endpackage : cps_pkg

/* cps_sink_model.sv */
/*
 * model of the downstream receiver and its link events: drives the
 * sink pins and one-cycle event pulses.
 * assumes the bench calls its tasks from one process at a time.
 */
module cps_sink_model
    import cps_pkg::*;
(
    // clock
    input wire logic clk,
    // toward the block
    output cps_pin_s sink_pins,
    output cps_evt_s evt
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        sink_pins = 3'b100;
        evt = '0;
    end

    // pins change off the sampling edge
    task set_pins(input cps_pin_s p);
        @(negedge clk);
        sink_pins = p;
    endtask : set_pins

    // key ready, list ready, pass, loss, error, hotplug pulses
    task pulse(input cps_evt_s e);
        @(negedge clk);
        evt = e;
        @(negedge clk);
        evt = '0;
    endtask : pulse
endmodule : cps_sink_model

/* cps_ctl_status_tb.sv */
/*
 * self-checking bench of the control and status registers.
 * assumes the sink model file and the package are compiled first.
 */
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("wrong value at %0t: got %h want %h", $time, got, exp); \
        end \
    end

module cps_ctl_status_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import cps_pkg::*;

    localparam cps_evt_s EV_KEY = 6'h20;
    localparam cps_evt_s EV_LIST = 6'h10;
    localparam cps_evt_s EV_PASS = 6'h08;
    localparam cps_evt_s EV_LOST = 6'h04;
    localparam cps_evt_s EV_ERR = 6'h02;
    localparam cps_evt_s EV_HPD = 6'h01;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr_en = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic rd_en = 1'b0;
    logic [7:0] rd_data;
    logic [1:0] enc_policy = CPS_POL_REG;
    logic frame_enc_req = 1'b0;
    cps_pin_s sink_pins;
    cps_evt_s evt;
    logic auth_enable, auth_restart, key_approved, list_approved;
    logic protect_reset, encrypt_on, blue_screen;
    int err_count = 0;
    int checks = 0;
    logic want;

    always #5 clk = ~clk;

    cps_ctl_status cps_ctl_status_inst (.clk(clk), .rst_n(rst_n),
        .addr(addr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
        .rd_data(rd_data), .enc_policy(enc_policy),
        .frame_enc_req(frame_enc_req), .sink_pins(sink_pins), .evt(evt),
        .auth_enable(auth_enable), .auth_restart(auth_restart),
        .key_approved(key_approved), .list_approved(list_approved),
        .protect_reset(protect_reset), .encrypt_on(encrypt_on),
        .blue_screen(blue_screen));

    cps_sink_model cps_sink_model_inst (.clk(clk), .sink_pins(sink_pins),
        .evt(evt));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr

    task rdc(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        `CHK(rd_data, exp)
    endtask : rdc

    task idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    task print_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        #20000;
        err_count++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        idle(3);
        rst_n = 1'b1;
        idle(3);
        rdc(CPS_ADDR_CTL, CPS_RST_CTL);
        rdc(CPS_ADDR_STS, 8'h40);
        rdc(8'h10, 8'h00);
        cps_sink_model_inst.set_pins(3'b011);
        idle(4);
        rdc(CPS_ADDR_STS, 8'h28);
        cps_sink_model_inst.set_pins(3'b111);
        idle(4);
        $display("test pins done");
        wr(CPS_ADDR_CTL, 8'h01);
        `CHK({auth_enable, auth_restart}, 2'b11)
        rdc(CPS_ADDR_CTL, 8'h01);
        wr(CPS_ADDR_CTL, 8'h00);
        `CHK({auth_enable, auth_restart}, 2'b10)
        cps_sink_model_inst.pulse(EV_PASS);
        rdc(CPS_ADDR_STS, 8'h69);
        wr(CPS_ADDR_CTL, 8'h01);
        `CHK(auth_restart, 1'b1)
        rdc(CPS_ADDR_STS, 8'h68);
        cps_sink_model_inst.pulse(EV_PASS);
        cps_sink_model_inst.pulse(EV_LOST);
        rdc(CPS_ADDR_STS, 8'h68);
        cps_sink_model_inst.pulse(EV_PASS);
        $display("test auth done");
        wr(CPS_ADDR_CTL, 8'h04);
        idle(3);
        `CHK({encrypt_on, blue_screen}, 2'b10)
        cps_sink_model_inst.pulse(EV_LOST);
        idle(3);
        `CHK({encrypt_on, blue_screen}, 2'b01)
        cps_sink_model_inst.pulse(EV_PASS);
        wr(CPS_ADDR_CTL, 8'h00);
        idle(3);
        `CHK({encrypt_on, blue_screen}, 2'b00)
        for (int e = 0; e < 2; e++)
        begin
            wr(CPS_ADDR_CTL, e ? 8'h04 : 8'h00);
            for (int p = 0; p < 4; p++)
            begin
                enc_policy = p[1:0];
                frame_enc_req = ~e[0];
                want = (p == 0) || (p == 2) || (p == 1 && e == 1);
                idle(3);
                `CHK(encrypt_on, want)
                rdc(CPS_ADDR_CTL, {5'h0, e[0] | p == 2, 2'h1});
            end
        end
        frame_enc_req = 1'b1;
        idle(3);
        `CHK(encrypt_on, 1'b1)
        enc_policy = CPS_POL_ALWAYS;
        wr(CPS_ADDR_CTL, 8'h00);
        cps_sink_model_inst.pulse(EV_LOST);
        idle(3);
        `CHK({encrypt_on, blue_screen}, 2'b01)
        cps_sink_model_inst.pulse(EV_PASS);
        enc_policy = CPS_POL_REG;
        rdc(CPS_ADDR_CTL, 8'h05);
        wr(CPS_ADDR_CTL, 8'h0c);
        idle(3);
        `CHK({encrypt_on, blue_screen}, 2'b00)
        rdc(CPS_ADDR_STS, 8'h69);
        wr(CPS_ADDR_CTL, 8'h04);
        idle(3);
        `CHK(encrypt_on, 1'b1)
        $display("test video done");
        cps_sink_model_inst.pulse(EV_KEY);
        rdc(CPS_ADDR_STS, 8'h6b);
        wr(CPS_ADDR_CTL, 8'h04);
        `CHK(key_approved, 1'b0)
        rdc(CPS_ADDR_STS, 8'h6b);
        wr(CPS_ADDR_CTL, 8'h14);
        `CHK(key_approved, 1'b1)
        rdc(CPS_ADDR_STS, 8'h69);
        rdc(CPS_ADDR_CTL, 8'h05);
        cps_sink_model_inst.pulse(EV_LIST);
        rdc(CPS_ADDR_STS, 8'h6d);
        wr(CPS_ADDR_CTL, 8'h24);
        `CHK(list_approved, 1'b1)
        rdc(CPS_ADDR_STS, 8'h69);
        $display("test keys done");
        cps_sink_model_inst.pulse(EV_ERR | EV_HPD);
        rdc(CPS_ADDR_STS, 8'hf9);
        rdc(CPS_ADDR_STS, 8'h69);
        fork
            rdc(CPS_ADDR_STS, 8'h69);
            cps_sink_model_inst.pulse(EV_HPD);
        join
        rdc(CPS_ADDR_STS, 8'h79);
        rdc(CPS_ADDR_STS, 8'h69);
        wr(CPS_ADDR_CTL, 8'h83);
        `CHK({protect_reset, auth_enable}, 2'b10)
        rdc(CPS_ADDR_STS, 8'h68);
        $display("test flags done");
        print_verdict();
    end
endmodule : cps_ctl_status_tb
